// File: rtl/rtcas_top.sv
// Contract
// - Prescale slow oscillator to one-second tick.
// - Cascade seconds 60, minutes 60, hours 24.
// - Day counter increments on each hour wrap.
// - Enabled interrupts on second, minute, hour, day.
// - Alarm interrupt when time equals alarm value.
// - First alarm compares hours, minutes, seconds.
// - Second alarm also compares the day count.
// - Stopwatch loads value, decrements each tick.
// - Stopwatch underflow raises its enabled interrupt.
`timescale 1ns/1ps
module rtcas_top
    import rtcas_pkg::*;
#(
    parameter int DIV     = PRESCALE_DIV,
    parameter int SW_W    = SWATCH_W
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    // Oscillator
    input  wire logic              slow_osc_input,
    // Register port
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    output logic      [DATA_W-1:0] rd_data,
    // Interrupt
    output logic                   irq
);

    // Timekeeping
    logic             tick;
    logic [5:0]       sec_cnt;
    logic [5:0]       min_cnt;
    logic [4:0]       hour_cnt;
    logic [DAY_W-1:0] day_cnt;
    logic             sec_wrap;
    logic             min_wrap;
    logic             hour_wrap;
    logic             time_ld;
    logic             day_ld;
    rtcas_time_type   time_wr;
    rtcas_time_type   time_cur;

    // Register state
    rtcas_time_type   alm1_r;
    rtcas_time_type   alm1_nxt;
    rtcas_time_type   alm2_r;
    rtcas_time_type   alm2_nxt;
    logic [DAY_W-1:0] alm2_day_r;
    logic [DAY_W-1:0] alm2_day_nxt;
    logic [SW_W-1:0]  sw_cnt_r;
    logic [SW_W-1:0]  sw_cnt_nxt;
    logic [CTRL_W-1:0] ctrl_r;
    logic [CTRL_W-1:0] ctrl_nxt;
    logic [IRQ_W-1:0] int_en_r;
    logic [IRQ_W-1:0] int_en_nxt;
    logic [IRQ_W-1:0] int_st_r;
    logic [IRQ_W-1:0] int_st_nxt;
    logic             tick_seen_r;
    logic             tick_seen_nxt;
    logic [DATA_W-1:0] rd_data_r;
    logic [DATA_W-1:0] rd_data_nxt;
    logic             irq_r;
    logic             irq_nxt;

    // Decode and events
    logic             wr_time;
    logic             wr_day;
    logic             wr_alm1;
    logic             wr_alm2;
    logic             wr_alm2day;
    logic             wr_sw;
    logic             wr_en_reg;
    logic             wr_st;
    logic             wr_ctrl;
    logic             rd_st;
    logic [IRQ_W-1:0] events;
    logic [IRQ_W-1:0] st_clr;
    logic             sw_under;

    rtcas_prescaler #(
        .DIV (DIV)
    ) u_prescaler (
        .clk_sys        (clk_sys),
        .rst_n          (rst_n),
        .slow_osc_input (slow_osc_input),
        .enable         (ctrl_r[CTRL_RUN]),
        .tick           (tick)
    );

    rtcas_wrap_counter #(
        .WIDTH   (6),
        .MODULUS (SEC_MOD)
    ) u_sec (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .inc      (tick),
        .load     (time_ld),
        .load_val (time_wr.second),
        .count    (sec_cnt),
        .wrap     (sec_wrap)
    );

    rtcas_wrap_counter #(
        .WIDTH   (6),
        .MODULUS (MIN_MOD)
    ) u_min (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .inc      (sec_wrap),
        .load     (time_ld),
        .load_val (time_wr.minute),
        .count    (min_cnt),
        .wrap     (min_wrap)
    );

    rtcas_wrap_counter #(
        .WIDTH   (5),
        .MODULUS (HOUR_MOD)
    ) u_hour (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .inc      (min_wrap),
        .load     (time_ld),
        .load_val (time_wr.hour),
        .count    (hour_cnt),
        .wrap     (hour_wrap)
    );

    // Day counter wraps over its full range
    rtcas_wrap_counter #(
        .WIDTH   (DAY_W),
        .MODULUS (DAY_MOD)
    ) u_day (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .inc      (hour_wrap),
        .load     (day_ld),
        .load_val (wr_data[DAY_W-1:0]),
        .count    (day_cnt),
        .wrap     ()
    );

    // Address decode
    always_comb begin
        wr_time    = 1'b0;
        wr_day     = 1'b0;
        wr_alm1    = 1'b0;
        wr_alm2    = 1'b0;
        wr_alm2day = 1'b0;
        wr_sw      = 1'b0;
        wr_en_reg  = 1'b0;
        wr_st      = 1'b0;
        wr_ctrl    = 1'b0;
        if (addr == OFS_TIME) begin
            wr_time = wr_en;
        end else if (addr == OFS_DAY) begin
            wr_day = wr_en;
        end else if (addr == OFS_ALM1) begin
            wr_alm1 = wr_en;
        end else if (addr == OFS_ALM2) begin
            wr_alm2 = wr_en;
        end else if (addr == OFS_ALM2DAY) begin
            wr_alm2day = wr_en;
        end else if (addr == OFS_SWATCH) begin
            wr_sw = wr_en;
        end else if (addr == OFS_INT_EN) begin
            wr_en_reg = wr_en;
        end else if (addr == OFS_INT_ST) begin
            wr_st = wr_en;
        end else if (addr == OFS_CTRL) begin
            wr_ctrl = wr_en;
        end
        rd_st = rd_en & (addr == OFS_INT_ST);
    end

    assign time_ld = wr_time;
    assign day_ld  = wr_day;
    assign time_wr = rtcas_unpack_time(wr_data);

    always_comb begin
        time_cur.hour   = hour_cnt;
        time_cur.minute = min_cnt;
        time_cur.second = sec_cnt;
    end

    // Alarm settings and interrupt enables
    always_comb begin
        alm1_nxt      = alm1_r;
        alm2_nxt      = alm2_r;
        alm2_day_nxt  = alm2_day_r;
        int_en_nxt    = int_en_r;
        // Alarms are compared once, just after the counters settle on a tick
        tick_seen_nxt = tick;

        if (wr_alm1) begin
            alm1_nxt = rtcas_unpack_time(wr_data);
        end
        if (wr_alm2) begin
            alm2_nxt = rtcas_unpack_time(wr_data);
        end
        if (wr_alm2day) begin
            alm2_day_nxt = wr_data[DAY_W-1:0];
        end
        if (wr_en_reg) begin
            int_en_nxt = wr_data[IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            alm1_r      <= '0;
            alm2_r      <= '0;
            alm2_day_r  <= '0;
            int_en_r    <= INT_EN_RST;
            tick_seen_r <= 1'b0;
        end else begin
            alm1_r      <= alm1_nxt;
            alm2_r      <= alm2_nxt;
            alm2_day_r  <= alm2_day_nxt;
            int_en_r    <= int_en_nxt;
            tick_seen_r <= tick_seen_nxt;
        end
    end

    // Stopwatch and run control
    always_comb begin
        sw_cnt_nxt = sw_cnt_r;
        ctrl_nxt   = ctrl_r;
        sw_under   = 1'b0;

        // Stopwatch counts down; stops at zero after underflow
        // A load of zero with run set underflows on the next tick
        if (tick && ctrl_r[CTRL_SW_RUN]) begin
            if (sw_cnt_r == '0) begin
                sw_under              = 1'b1;
                ctrl_nxt[CTRL_SW_RUN] = 1'b0;
            end else begin
                sw_cnt_nxt = sw_cnt_r - 1'b1;
            end
        end

        // Software writes win over hardware updates of the same cycle
        if (wr_sw) begin
            sw_cnt_nxt = wr_data[SW_W-1:0];
        end
        if (wr_ctrl) begin
            ctrl_nxt = wr_data[CTRL_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sw_cnt_r <= '0;
            ctrl_r   <= CTRL_RST;
        end else begin
            sw_cnt_r <= sw_cnt_nxt;
            ctrl_r   <= ctrl_nxt;
        end
    end

    // Interrupt status and output
    always_comb begin
        // The mask gates the output only; status always records events
        events             = '0;
        events[IRQ_SEC]    = tick;
        events[IRQ_MIN]    = sec_wrap;
        events[IRQ_HOUR]   = min_wrap;
        events[IRQ_DAY]    = hour_wrap;
        events[IRQ_ALM1]   = tick_seen_r && (time_cur == alm1_r);
        events[IRQ_ALM2]   = tick_seen_r && (time_cur == alm2_r)
                             && (day_cnt == alm2_day_r);
        events[IRQ_SWATCH] = sw_under;

        // Clear by write-one or by read; a new event wins over the clear
        st_clr = '0;
        if (wr_st) begin
            st_clr = wr_data[IRQ_W-1:0];
        end
        if (rd_st) begin
            st_clr = st_clr | int_st_r;
        end
        int_st_nxt = (int_st_r & ~st_clr) | events;
        irq_nxt    = |(int_st_nxt & int_en_nxt);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            int_st_r <= '0;
            irq_r    <= 1'b0;
        end else begin
            int_st_r <= int_st_nxt;
            irq_r    <= irq_nxt;
        end
    end

    // Read data one cycle after the strobe; unmapped reads give zero
    always_comb begin
        rd_data_nxt = '0;
        if (rd_en) begin
            if (addr == OFS_TIME) begin
                rd_data_nxt = rtcas_pack_time(time_cur);
            end else if (addr == OFS_DAY) begin
                rd_data_nxt = DATA_W'(day_cnt);
            end else if (addr == OFS_ALM1) begin
                rd_data_nxt = rtcas_pack_time(alm1_r);
            end else if (addr == OFS_ALM2) begin
                rd_data_nxt = rtcas_pack_time(alm2_r);
            end else if (addr == OFS_ALM2DAY) begin
                rd_data_nxt = DATA_W'(alm2_day_r);
            end else if (addr == OFS_SWATCH) begin
                rd_data_nxt = DATA_W'(sw_cnt_r);
            end else if (addr == OFS_INT_EN) begin
                rd_data_nxt = DATA_W'(int_en_r);
            end else if (addr == OFS_INT_ST) begin
                rd_data_nxt = DATA_W'(int_st_r);
            end else if (addr == OFS_CTRL) begin
                rd_data_nxt = DATA_W'(ctrl_r);
            end
        end
    end

    // Zero outside a read keeps stale words off the port
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_r <= '0;
        end else begin
            rd_data_r <= rd_data_nxt;
        end
    end

    assign rd_data = rd_data_r;
    assign irq     = irq_r;

endmodule

// File: rtl/rtcas_pkg.sv
package rtcas_pkg;

    // Bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_TIME    = 8'h00;
    localparam logic [7:0] OFS_DAY     = 8'h04;
    localparam logic [7:0] OFS_ALM1    = 8'h08;
    localparam logic [7:0] OFS_ALM2    = 8'h0c;
    localparam logic [7:0] OFS_ALM2DAY = 8'h10;
    localparam logic [7:0] OFS_SWATCH  = 8'h14;
    localparam logic [7:0] OFS_INT_EN  = 8'h18;
    localparam logic [7:0] OFS_INT_ST  = 8'h1c;
    localparam logic [7:0] OFS_CTRL    = 8'h20;

    // Time word field positions
    localparam int SEC_LSB  = 0;
    localparam int MIN_LSB  = 8;
    localparam int HOUR_LSB = 16;

    // Counter moduli and widths
    localparam int PRESCALE_DIV = 32768;
    localparam int SEC_MOD      = 60;
    localparam int MIN_MOD      = 60;
    localparam int HOUR_MOD     = 24;
    localparam int DAY_MOD      = 32768;
    localparam int DAY_W        = 15;
    localparam int SWATCH_W     = 32;

    // Interrupt bit positions
    localparam int IRQ_SEC    = 0;
    localparam int IRQ_MIN    = 1;
    localparam int IRQ_HOUR   = 2;
    localparam int IRQ_DAY    = 3;
    localparam int IRQ_ALM1   = 4;
    localparam int IRQ_ALM2   = 5;
    localparam int IRQ_SWATCH = 6;
    localparam int IRQ_W      = 7;

    // Control bits and reset values
    localparam int CTRL_RUN    = 0;
    localparam int CTRL_SW_RUN = 1;
    localparam int CTRL_W      = 2;
    localparam logic [1:0] CTRL_RST   = 2'h1;
    localparam logic [6:0] INT_EN_RST = 7'h00;

    typedef struct packed {
        logic [4:0] hour;
        logic [5:0] minute;
        logic [5:0] second;
    } rtcas_time_type;

    function automatic logic [31:0] rtcas_pack_time(input rtcas_time_type t);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[SEC_LSB +: 6]  = t.second;
        w[MIN_LSB +: 6]  = t.minute;
        w[HOUR_LSB +: 5] = t.hour;
        return w;
    endfunction

    function automatic rtcas_time_type rtcas_unpack_time(input logic [31:0] w);
        rtcas_time_type t;
        t.second = w[SEC_LSB +: 6];
        t.minute = w[MIN_LSB +: 6];
        t.hour   = w[HOUR_LSB +: 5];
        return t;
    endfunction

endpackage

// File: rtl/rtcas_prescaler.sv
`timescale 1ns/1ps
module rtcas_prescaler
    import rtcas_pkg::*;
#(
    parameter int DIV = PRESCALE_DIV
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // Oscillator and control
    input  wire logic slow_osc_input,
    input  wire logic enable,
    // One-second strobe
    output logic      tick
);
    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic          osc_d_r;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          tick_r;
    logic          tick_nxt;
    logic          edge_seen;

    always_comb begin
        edge_seen = slow_osc_input & ~osc_d_r;
        cnt_nxt   = cnt_r;
        tick_nxt  = 1'b0;
        // Clearing on disable gives a full second after restart
        if (!enable) begin
            cnt_nxt = '0;
        end else if (edge_seen) begin
            if (cnt_r == LAST) begin
                cnt_nxt  = '0;
                tick_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            osc_d_r <= 1'b0;
            cnt_r   <= '0;
            tick_r  <= 1'b0;
        end else begin
            osc_d_r <= slow_osc_input;
            cnt_r   <= cnt_nxt;
            tick_r  <= tick_nxt;
        end
    end

    assign tick = tick_r;

endmodule

// File: rtl/rtcas_wrap_counter.sv
`timescale 1ns/1ps
module rtcas_wrap_counter
    import rtcas_pkg::*;
#(
    parameter int WIDTH   = 6,
    parameter int MODULUS = SEC_MOD
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // Control
    input  wire logic             inc,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_val,
    // Count and carry
    output logic      [WIDTH-1:0] count,
    output logic                  wrap
);
    localparam logic [WIDTH-1:0] LAST = WIDTH'(MODULUS - 1);

    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;
    logic             at_last;

    always_comb begin
        // Out-of-range loads wrap at the next step instead of running on
        at_last   = (count_r >= LAST);
        count_nxt = count_r;
        if (load) begin
            count_nxt = load_val;
        end else if (inc) begin
            if (at_last) begin
                count_nxt = '0;
            end else begin
                count_nxt = count_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign count = count_r;
    assign wrap  = inc & ~load & at_last;

endmodule

// File: sim/rtcas_osc_model.sv
`timescale 1ns/1ps
module rtcas_osc_model #(
    parameter int HALF_NS = 80
) (
    // Oscillator
    output logic slow_osc_input
);
    // Free running like a crystal; the odd offset keeps its edges off the clk_sys edges
    initial begin
        slow_osc_input = 1'b0;
        #3;
        forever #HALF_NS slow_osc_input = ~slow_osc_input;
    end
endmodule

// File: sim/rtcas_sva.sv
`timescale 1ns/1ps
module rtcas_sva
    import rtcas_pkg::*;
#(
    parameter int DIV = PRESCALE_DIV
) (
    // Clock and reset
    input wire logic              clk_sys,
    input wire logic              rst_n,
    // Watched ports
    input wire logic              slow_osc_input,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic              wr_en,
    input wire logic              rd_en,
    input wire logic [DATA_W-1:0] rd_data,
    input wire logic              irq
);
    logic [6:0]  en_r, en_nxt;
    logic [31:0] alm1_r, alm1_nxt;
    logic [14:0] a2d_r, a2d_nxt;
    logic [3:0]  age_r, age_nxt;
    logic        osc_r;

    // Shadows of written values; age counts cycles since the last oscillator rise
    always_comb begin
        en_nxt   = en_r;
        alm1_nxt = alm1_r;
        a2d_nxt  = a2d_r;
        if (wr_en && addr == OFS_INT_EN) en_nxt = wr_data[6:0];
        if (wr_en && addr == OFS_ALM1) alm1_nxt = wr_data & 32'h001f3f3f;
        if (wr_en && addr == OFS_ALM2DAY) a2d_nxt = wr_data[14:0];
        age_nxt = (age_r == 4'hf) ? age_r : age_r + 4'h1;
        if (slow_osc_input && !osc_r) age_nxt = 4'h0;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            en_r   <= 7'h00;
            alm1_r <= 32'h0;
            a2d_r  <= 15'h0;
            age_r  <= 4'hf;
            osc_r  <= 1'b0;
        end else begin
            en_r   <= en_nxt;
            alm1_r <= alm1_nxt;
            a2d_r  <= a2d_nxt;
            age_r  <= age_nxt;
            osc_r  <= slow_osc_input;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    chk_tick_after_osc: assert property ($rose(irq) && en_r == 7'h01 && $past(en_r) == 7'h01
        |-> age_r <= 4'ha) else $error("second interrupt not tied to an oscillator edge");
    chk_time_fields: assert property (rd_en && addr == OFS_TIME
        |=> (rd_data & ~32'h001f3f3f) == 32'h0 && rd_data[5:0] < 6'h3c && rd_data[13:8] < 6'h3c
            && rd_data[20:16] < 5'h18) else $error("time word out of range");
    chk_day_width: assert property (rd_en && addr == OFS_DAY |=> rd_data[31:15] == 17'h0)
        else $error("day word too wide");
    chk_en_readback: assert property (rd_en && addr == OFS_INT_EN
        |=> rd_data == {25'h0, $past(en_r)}) else $error("enable read back differs");
    chk_alm1_readback: assert property (rd_en && addr == OFS_ALM1
        |=> rd_data == $past(alm1_r)) else $error("first alarm read back differs");
    chk_alm2_day: assert property (rd_en && addr == OFS_ALM2DAY
        |=> rd_data == {17'h0, $past(a2d_r)}) else $error("second alarm day differs");
    chk_irq_masked: assert property (en_r == 7'h00 |-> !irq)
        else $error("interrupt high with all sources disabled");
    chk_irq_sticky: assert property (irq && !(wr_en && (addr == OFS_INT_ST || addr == OFS_INT_EN))
        && !(rd_en && addr == OFS_INT_ST) |=> irq) else $error("interrupt dropped without a clear");

    cover property (rd_en && addr == OFS_INT_ST && irq);
    cover property ($rose(irq));
    cover property ($fell(irq));
endmodule

// File: sim/rtcas_tb_top.sv
`timescale 1ns/1ps
module rtcas_tb_top;
    import rtcas_pkg::*;
    localparam int DIV = 4;
    logic              clk_sys, rst_n, slow_osc_input, wr_en, rd_en, irq, rd_pend;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wr_data, rd_data, d;
    logic [31:0]       exp_q[$];
    int                bad_count, tests_run, seed, i;

    rtcas_top #(.DIV(DIV)) DUT (
        .clk_sys(clk_sys), .rst_n(rst_n), .slow_osc_input(slow_osc_input), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq)
    );
    rtcas_osc_model u_osc (.slow_osc_input(slow_osc_input));

    always #5 clk_sys = ~clk_sys;

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wrap_up();
        if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        addr    <= a;
        wr_data <= v;
        wr_en   <= 1'b1;
        @(posedge clk_sys);
        wr_en   <= 1'b0;
    endtask

    // The expected word is noted first; the watcher below pairs it with the answer
    task automatic rd(input logic [7:0] a, input logic [31:0] v);
        exp_q.push_back(v);
        @(posedge clk_sys);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
    endtask

    // Sampled on the falling edge so the strobe edge has settled first
    task automatic wait_irq(input int lim);
        int n;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
            if (n > lim) begin
                chk("irq wait", irq, 1'b1);
                wrap_up();
            end
        end while (irq !== 1'b1);
    endtask

    // Stop the clock, load time and day, clear status, then restart
    task automatic start(input logic [31:0] t, input logic [31:0] dy, input logic [31:0] en,
                         input logic [31:0] ctl);
        wr(OFS_CTRL, 32'h0);
        wr(OFS_TIME, t);
        wr(OFS_DAY, dy);
        wr(OFS_INT_ST, 32'h7f);
        wr(OFS_INT_EN, en);
        wr(OFS_CTRL, ctl);
    endtask

    always @(negedge clk_sys) begin
        if (rd_pend) chk("rd_data", rd_data, exp_q.pop_front());
        rd_pend = rd_en;
    end

    initial begin
        #500000;
        chk("run time", 32'h0, 32'h1);
        wrap_up();
    end

    initial begin
        clk_sys = 1'b0;
        rst_n   = 1'b0;
        addr    = 8'h00;
        wr_data = 32'h0;
        wr_en   = 1'b0;
        rd_en   = 1'b0;
        rd_pend = 1'b0;
        seed    = 32'h3fad;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(OFS_CTRL, 32'h1);
        rd(OFS_INT_EN, 32'h0);
        wr(OFS_CTRL, 32'h0);
        for (i = 0; i < 4; i++) begin
            d = $random(seed);
            wr(OFS_ALM1, d);
            rd(OFS_ALM1, d & 32'h001f3f3f);
            wr(OFS_ALM2DAY, d);
            rd(OFS_ALM2DAY, d & 32'h7fff);
        end
        wr(8'h40, 32'hffffffff);
        rd(8'h40, 32'h0);
        // Every rollover in one tick; both alarms sit at midnight of day zero
        wr(OFS_ALM1, 32'h0);
        wr(OFS_ALM2, 32'h0);
        wr(OFS_ALM2DAY, 32'h0);
        start(32'h00173b3b, 32'h7fff, 32'h0f, 32'h1);
        wait_irq(200);
        rd(OFS_INT_ST, 32'h3f);
        rd(OFS_TIME, 32'h0);
        rd(OFS_DAY, 32'h0);
        @(negedge clk_sys);
        chk("irq", irq, 1'b0);
        // An ordinary midnight advances the day; the dated alarm stays quiet
        start(32'h00173b3b, 32'h5, 32'h08, 32'h1);
        wait_irq(200);
        rd(OFS_DAY, 32'h6);
        rd(OFS_INT_ST, 32'h1f);
        // Status still sets while its enable is off
        start(32'h0000000a, 32'h0, 32'h01, 32'h1);
        wait_irq(200);
        rd(OFS_INT_ST, 32'h01);
        rd(OFS_TIME, 32'h0000000b);
        wr(OFS_INT_EN, 32'h0);
        repeat (80) @(negedge clk_sys);
        chk("irq", irq, 1'b0);
        wr(OFS_INT_EN, 32'h01);
        @(negedge clk_sys);
        chk("irq", irq, 1'b1);
        wr(OFS_INT_ST, 32'h1);
        rd(OFS_INT_ST, 32'h0);
        // Daily alarm matches on day 2; the dated one needs day 3
        wr(OFS_ALM1, 32'h5);
        wr(OFS_ALM2, 32'h5);
        wr(OFS_ALM2DAY, 32'h3);
        start(32'h4, 32'h2, 32'h30, 32'h1);
        wait_irq(200);
        rd(OFS_INT_ST, 32'h11);
        start(32'h4, 32'h3, 32'h30, 32'h1);
        wait_irq(200);
        rd(OFS_INT_ST, 32'h31);
        // Stopwatch from 2: two decrements, underflow on the third tick
        wr(OFS_SWATCH, 32'h2);
        start(32'h00000a00, 32'h0, 32'h01, 32'h3);
        for (i = 0; i < 2; i++) begin
            wait_irq(200);
            rd(OFS_INT_ST, 32'h01);
            rd(OFS_SWATCH, 32'h1 - 32'(i));
        end
        wr(OFS_INT_EN, 32'h40);
        wait_irq(200);
        rd(OFS_INT_ST, 32'h41);
        rd(OFS_CTRL, 32'h1);
        rd(OFS_SWATCH, 32'h0);
        repeat (3) @(negedge clk_sys);
        wrap_up();
    end
endmodule

bind rtcas_top rtcas_sva #(.DIV(DIV)) u_sva (
    .clk_sys(clk_sys), .rst_n(rst_n), .slow_osc_input(slow_osc_input), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq)
);
